// ### shared/serdes_lane_status_pkg.sv
package serdes_lane_status_pkg;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_TBUS_READBACK = 32'h0231_e0f8;
    localparam logic [31:0] ADDR_TBUS_SELECT = 32'h0231_e0fc;
    localparam logic [31:0] ADDR_LANE0_CFG4 = 32'h0231_e204;
    localparam logic [31:0] ADDR_LANE1_CFG4 = 32'h0231_e404;
    localparam logic [31:0] ADDR_LANE0_CTL_STS = 32'h0231_ffe0;
    localparam logic [31:0] ADDR_LANE1_CTL_STS = 32'h0231_ffe4;
    localparam logic [31:0] ADDR_PLL_LANE_STS = 32'h0231_fff4;
    localparam logic [31:0] ADDR_PORT0_TX_CTL = 32'h02f0_0600;
    localparam logic [31:0] ADDR_PORT0_RX_STS = 32'h02f0_060c;
    localparam logic [31:0] ADDR_PORT1_TX_CTL = 32'h02f0_0680;
    localparam logic [31:0] ADDR_PORT1_RX_STS = 32'h02f0_068c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PLL_SIGDET_LSB = 0;
    localparam int PLL_SIGOK_LSB = 8;
    localparam int PLL2_OK_BIT = 24;
    localparam int PLL_OK_BIT = 28;
    localparam int LCS_RX_LOSS_BIT = 0;
    localparam int LCS_RX_OK_BIT = 1;
    localparam int LCS_LINK_UP_BIT = 20;
    localparam int CFG_OVR_VAL_BIT = 1;
    localparam int CFG_OVR_EN_BIT = 2;
    localparam int CFG_BOOST_ESCAPE_BIT = 3;
    localparam int CFG_EIDLE_CAL_BIT = 7;
    localparam int CFG_THR_LSB = 24;
    localparam int CFG_THR_MSB = 31;
    localparam int RXS_ERR_LSB = 16;
    localparam int RXS_ERR_MSB = 23;
    localparam int RXS_LINKED_BIT = 30;
    localparam int TBUS_ATT_LSB = 20;
    localparam int TBUS_ATT_MSB = 23;
    localparam int TBUS_BOOST_LSB = 24;
    localparam int TBUS_BOOST_MSB = 27;
    localparam logic [31:0] TBUS_SEL_PORT0 = 32'h0210_0000;
    localparam logic [31:0] TBUS_SEL_PORT1 = 32'h0310_0000;

    // ----------------------------------------------------------------
    // Reset values and saturation limits
    // ----------------------------------------------------------------
    localparam logic [31:0] CFG4_RESET = 32'h0000_0080;
    localparam logic [31:0] TX_CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] TBUS_SEL_RESET = 32'h0000_0000;
    localparam logic [7:0] ERR_CNT_MAX = 8'hff;
    localparam logic [3:0] BOOST_MAX = 4'hf;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] envelope;
        logic signal_ok;
        logic rx_loss;
        logic rx_ok;
        logic link_up;
        logic rx_linked;
        logic block_error;
        logic adapt_up;
        logic adapt_dn;
        logic [3:0] att;
    } lane_in_t;

    typedef struct packed {
        logic signal_detect;
        logic rx_stage_reset;
        logic recal;
        logic cdr_reset;
        logic lane_reset;
    } lane_out_t;

    typedef struct packed {
        logic [3:0] boost;
        logic stuck;
        logic sigdet;
        logic ovr_en_prev;
        logic [7:0] err_cnt;
        logic stage_pulse;
        logic cdr_pulse;
        logic lane_rst_pulse;
        logic read_left;
        logic blocked;
    } lane_state_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic err;
        logic [31:0] tbus_sel;
        logic [1:0][31:0] cfg;
        logic [1:0][31:0] tx_ctl;
        lane_state_t [1:0] lane;
        logic [1:0][31:0] tx_data;
        logic [1:0][31:0] rx_data;
    } state_t;

endpackage

// ### core/serdes_lane_status.sv
`timescale 1ns/1ps
`default_nettype none
module serdes_lane_status #(
    parameter int unsigned SERDES_WIDTH = 32,
    parameter logic [3:0] BOOST_START = 4'h8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_ok,
    input wire logic pll2_ok,
    input wire logic [1:0] kr_mode,
    input wire serdes_lane_status_pkg::lane_in_t [1:0] lane_in,
    output serdes_lane_status_pkg::lane_out_t [1:0] lane_out,
    input wire logic [1:0][SERDES_WIDTH-1:0] xgmii_tx_data,
    output logic [1:0][SERDES_WIDTH-1:0] serdes_tx_data,
    input wire logic [1:0][SERDES_WIDTH-1:0] serdes_rx_data,
    output logic [1:0][SERDES_WIDTH-1:0] xgmii_rx_data
);

    serdes_lane_status_pkg::state_t q;
    serdes_lane_status_pkg::state_t d;

    logic setup;
    logic access;
    logic [31:0] rd;
    logic hit;
    logic pcs_hit;
    logic pcs_port;

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign setup = psel & ~penable;
    assign access = psel & penable;

    // ----------------------------------------------------------------
    // Read decode, evaluated in the setup phase
    // ----------------------------------------------------------------
    always_comb begin
        rd = '0;
        hit = 1'b1;
        pcs_hit = 1'b0;
        pcs_port = 1'b0;
        case (paddr)
            serdes_lane_status_pkg::ADDR_PLL_LANE_STS: begin
                for (int i = 0; i < 2; i++) begin
                    rd[serdes_lane_status_pkg::PLL_SIGDET_LSB + i] =
                        q.lane[i].sigdet;
                    rd[serdes_lane_status_pkg::PLL_SIGOK_LSB + i] =
                        lane_in[i].signal_ok;
                end
                rd[serdes_lane_status_pkg::PLL2_OK_BIT] = pll2_ok;
                rd[serdes_lane_status_pkg::PLL_OK_BIT] = pll_ok;
            end
            serdes_lane_status_pkg::ADDR_LANE0_CTL_STS,
            serdes_lane_status_pkg::ADDR_LANE1_CTL_STS: begin
                pcs_port = paddr[2];
                rd[serdes_lane_status_pkg::LCS_RX_LOSS_BIT] =
                    lane_in[pcs_port].rx_loss;
                rd[serdes_lane_status_pkg::LCS_RX_OK_BIT] =
                    lane_in[pcs_port].rx_ok;
                rd[serdes_lane_status_pkg::LCS_LINK_UP_BIT] =
                    lane_in[pcs_port].link_up;
                pcs_port = 1'b0;
            end
            serdes_lane_status_pkg::ADDR_TBUS_SELECT: begin
                rd = q.tbus_sel;
            end
            serdes_lane_status_pkg::ADDR_TBUS_READBACK: begin
                // Unknown selections read zero
                if (q.tbus_sel == serdes_lane_status_pkg::TBUS_SEL_PORT0) begin
                    rd[serdes_lane_status_pkg::TBUS_ATT_MSB:
                       serdes_lane_status_pkg::TBUS_ATT_LSB] =
                        lane_in[0].att;
                    rd[serdes_lane_status_pkg::TBUS_BOOST_MSB:
                       serdes_lane_status_pkg::TBUS_BOOST_LSB] =
                        q.lane[0].boost;
                end else if (q.tbus_sel ==
                             serdes_lane_status_pkg::TBUS_SEL_PORT1) begin
                    rd[serdes_lane_status_pkg::TBUS_ATT_MSB:
                       serdes_lane_status_pkg::TBUS_ATT_LSB] =
                        lane_in[1].att;
                    rd[serdes_lane_status_pkg::TBUS_BOOST_MSB:
                       serdes_lane_status_pkg::TBUS_BOOST_LSB] =
                        q.lane[1].boost;
                end
            end
            serdes_lane_status_pkg::ADDR_LANE0_CFG4: begin
                rd = q.cfg[0];
            end
            serdes_lane_status_pkg::ADDR_LANE1_CFG4: begin
                rd = q.cfg[1];
            end
            serdes_lane_status_pkg::ADDR_PORT0_TX_CTL: begin
                pcs_hit = 1'b1;
                rd = q.tx_ctl[0];
            end
            serdes_lane_status_pkg::ADDR_PORT1_TX_CTL: begin
                pcs_hit = 1'b1;
                pcs_port = 1'b1;
                rd = q.tx_ctl[1];
            end
            serdes_lane_status_pkg::ADDR_PORT0_RX_STS: begin
                pcs_hit = 1'b1;
                rd[serdes_lane_status_pkg::RXS_LINKED_BIT] =
                    lane_in[0].rx_linked;
                rd[serdes_lane_status_pkg::RXS_ERR_MSB:
                   serdes_lane_status_pkg::RXS_ERR_LSB] =
                    q.lane[0].err_cnt;
            end
            serdes_lane_status_pkg::ADDR_PORT1_RX_STS: begin
                pcs_hit = 1'b1;
                pcs_port = 1'b1;
                rd[serdes_lane_status_pkg::RXS_LINKED_BIT] =
                    lane_in[1].rx_linked;
                rd[serdes_lane_status_pkg::RXS_ERR_MSB:
                   serdes_lane_status_pkg::RXS_ERR_LSB] =
                    q.lane[1].err_cnt;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic ovr_en;
        logic ovr_val;
        logic sd;
        logic cdr;
        logic [7:0] thr;
        ovr_en = 1'b0;
        ovr_val = 1'b0;
        sd = 1'b0;
        cdr = 1'b0;
        thr = '0;
        d = q;

        // Bus: latch answer in setup, commit side effects at access
        if (setup) begin
            d.err = ~hit | (pcs_hit & q.lane[pcs_port].blocked);
            d.rdata = (hit & ~(pcs_hit & q.lane[pcs_port].blocked)) ?
                rd : '0;
        end
        if (access & ~q.err) begin
            // One access after a KR lane reset, then the port locks
            if (pcs_hit & q.lane[pcs_port].read_left) begin
                d.lane[pcs_port].read_left = 1'b0;
                d.lane[pcs_port].blocked = 1'b1;
            end
            if (pwrite) begin
                case (paddr)
                    serdes_lane_status_pkg::ADDR_TBUS_SELECT: begin
                        d.tbus_sel = merge(q.tbus_sel, pwdata, pstrb);
                    end
                    serdes_lane_status_pkg::ADDR_LANE0_CFG4,
                    serdes_lane_status_pkg::ADDR_LANE1_CFG4: begin
                        d.cfg[paddr[10]] = merge(q.cfg[paddr[10]], pwdata,
                            pstrb);
                        // Rewriting the lane counts as reconfiguration
                        d.lane[paddr[10]].blocked = 1'b0;
                        d.lane[paddr[10]].read_left = 1'b0;
                        if (pstrb[0] &
                            pwdata[serdes_lane_status_pkg::CFG_BOOST_ESCAPE_BIT])
                        begin
                            d.lane[paddr[10]].stuck = 1'b0;
                            d.lane[paddr[10]].boost = BOOST_START;
                        end
                    end
                    serdes_lane_status_pkg::ADDR_PORT0_TX_CTL,
                    serdes_lane_status_pkg::ADDR_PORT1_TX_CTL: begin
                        d.tx_ctl[paddr[7]] = merge(q.tx_ctl[paddr[7]], pwdata,
                            pstrb);
                    end
                    serdes_lane_status_pkg::ADDR_PORT0_RX_STS,
                    serdes_lane_status_pkg::ADDR_PORT1_RX_STS: begin
                        // Any write clears the errored block count
                        d.lane[paddr[7]].err_cnt = '0;
                    end
                    default: begin
                    end
                endcase
            end
        end

        for (int i = 0; i < 2; i++) begin
            ovr_en = q.cfg[i][serdes_lane_status_pkg::CFG_OVR_EN_BIT];
            ovr_val = q.cfg[i][serdes_lane_status_pkg::CFG_OVR_VAL_BIT];
            thr = q.cfg[i][serdes_lane_status_pkg::CFG_THR_MSB:
                           serdes_lane_status_pkg::CFG_THR_LSB];
            sd = ovr_en ? ovr_val :
                (lane_in[i].envelope > thr);
            d.lane[i].sigdet = sd;
            d.lane[i].ovr_en_prev = ovr_en;
            d.lane[i].stage_pulse = ovr_en & ~q.lane[i].ovr_en_prev &
                q.cfg[i][serdes_lane_status_pkg::CFG_EIDLE_CAL_BIT];
            cdr = q.lane[i].sigdet & ~sd;
            d.lane[i].cdr_pulse = cdr;
            // XFI keeps the lane; KR resets it and arms one access
            d.lane[i].lane_rst_pulse = cdr & kr_mode[i];
            if (cdr & kr_mode[i]) begin
                d.lane[i].read_left = 1'b1;
                d.lane[i].blocked = 1'b0;
            end

            // Boost adaptation; a zero boost survives CDR resets
            if (cdr & ~d.lane[i].stuck) begin
                d.lane[i].boost = BOOST_START;
            end else if (lane_in[i].adapt_dn) begin
                if (d.lane[i].boost <= 4'h1) begin
                    d.lane[i].boost = 4'h0;
                    d.lane[i].stuck = 1'b1;
                end else begin
                    d.lane[i].boost = d.lane[i].boost - 4'h1;
                end
            end else if (lane_in[i].adapt_up & ~d.lane[i].stuck &
                         (d.lane[i].boost != serdes_lane_status_pkg::BOOST_MAX))
            begin
                d.lane[i].boost = d.lane[i].boost + 4'h1;
            end

            // Count after any clear so a same-cycle error is kept
            if (lane_in[i].block_error &
                (d.lane[i].err_cnt != serdes_lane_status_pkg::ERR_CNT_MAX))
            begin
                d.lane[i].err_cnt = d.lane[i].err_cnt + 8'h01;
            end

            d.tx_data[i] = 32'(xgmii_tx_data[i]);
            d.rx_data[i] = 32'(serdes_rx_data[i]);
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.rdata <= '0;
            q.err <= 1'b0;
            q.tbus_sel <= serdes_lane_status_pkg::TBUS_SEL_RESET;
            for (int i = 0; i < 2; i++) begin
                q.cfg[i] <= serdes_lane_status_pkg::CFG4_RESET;
                q.tx_ctl[i] <= serdes_lane_status_pkg::TX_CTL_RESET;
                q.lane[i] <= '{boost: BOOST_START, default: '0};
                q.tx_data[i] <= '0;
                q.rx_data[i] <= '0;
            end
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = q.rdata;
    assign pready = access;
    assign pslverr = access & q.err;

    for (genvar g = 0; g < 2; g++) begin : g_lane
        assign lane_out[g].signal_detect = q.lane[g].sigdet;
        assign lane_out[g].rx_stage_reset = q.lane[g].stage_pulse;
        assign lane_out[g].recal = q.lane[g].stage_pulse;
        assign lane_out[g].cdr_reset = q.lane[g].cdr_pulse;
        assign lane_out[g].lane_reset = q.lane[g].lane_rst_pulse;
        assign serdes_tx_data[g] = q.tx_data[g][SERDES_WIDTH-1:0];
        assign xgmii_rx_data[g] = q.rx_data[g][SERDES_WIDTH-1:0];
    end

endmodule
`default_nettype wire

// ### verification/serdes_lane_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module serdes_lane_status_asserts #(
    parameter int unsigned SERDES_WIDTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pll_ok,
    input wire logic pll2_ok,
    input wire logic [1:0] kr_mode,
    input wire serdes_lane_status_pkg::lane_in_t [1:0] lane_in,
    input wire serdes_lane_status_pkg::lane_out_t [1:0] lane_out,
    input wire logic [1:0][SERDES_WIDTH-1:0] xgmii_tx_data,
    input wire logic [1:0][SERDES_WIDTH-1:0] serdes_tx_data,
    input wire logic [1:0][SERDES_WIDTH-1:0] serdes_rx_data,
    input wire logic [1:0][SERDES_WIDTH-1:0] xgmii_rx_data
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_access: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_err_access: assert property (pslverr |-> penable && prdata == '0)
        else $error("error outside access or with data");
    a_unmapped_err: assert property (psel && !penable && paddr == '0
        ##1 psel && penable |-> pslverr)
        else $error("unmapped access not refused");
    a_tx_path: assert property ($past(presetn) |->
        serdes_tx_data == $past(xgmii_tx_data))
        else $error("transmit path not one cycle");
    a_rx_path: assert property ($past(presetn) |->
        xgmii_rx_data == $past(serdes_rx_data))
        else $error("receive path not one cycle");
    a_cdr_fall: assert property ($fell(lane_out[0].signal_detect)
        |-> ##[0:2] lane_out[0].cdr_reset)
        else $error("no clock recovery reset after detect fell");
    a_cdr_low: assert property (lane_out[1].cdr_reset |->
        !lane_out[1].signal_detect)
        else $error("clock recovery reset while detect high");
    a_xfi_no_reset: assert property (!kr_mode[0] |->
        !lane_out[0].lane_reset)
        else $error("lane reset in XFI mode");
    a_kr_reset: assert property (lane_out[1].lane_reset |->
        kr_mode[1] && !lane_out[1].signal_detect)
        else $error("lane reset without KR detect drop");
    a_stage_recal: assert property (lane_out[0].rx_stage_reset |->
        lane_out[0].recal ##1 !lane_out[0].rx_stage_reset)
        else $error("stage reset not a single recal pulse");
    a_pll_detect: assert property (psel && !penable && !pwrite &&
        paddr == serdes_lane_status_pkg::ADDR_PLL_LANE_STS ##1 penable
        |-> prdata[1:0] == $past({lane_out[1].signal_detect,
        lane_out[0].signal_detect}))
        else $error("status detect bits differ from lanes");
endmodule

bind serdes_lane_status serdes_lane_status_asserts #(
    .SERDES_WIDTH(SERDES_WIDTH)
) u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_ok(pll_ok), .pll2_ok(pll2_ok), .kr_mode(kr_mode),
    .lane_in(lane_in), .lane_out(lane_out),
    .xgmii_tx_data(xgmii_tx_data), .serdes_tx_data(serdes_tx_data),
    .serdes_rx_data(serdes_rx_data), .xgmii_rx_data(xgmii_rx_data)
);
`default_nettype wire

// ### verification/link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module link_partner #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] healthy,
    input wire logic [1:0][7:0] env,
    input wire logic [1:0] err_req,
    input wire logic [1:0] dn_req,
    input wire logic [1:0] up_req,
    input wire logic [1:0][W-1:0] serdes_tx_data,
    output logic [1:0][W-1:0] serdes_rx_data,
    output var serdes_lane_status_pkg::lane_in_t [1:0] lane_in
);
    // Events every other cycle so each one is a clean pulse
    logic ph_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 1'b0;
            serdes_rx_data <= '0;
            lane_in <= '0;
        end else begin
            ph_q <= !ph_q;
            // Far-end loopback
            serdes_rx_data <= serdes_tx_data;
            for (int i = 0; i < 2; i++) begin
                lane_in[i].envelope <= env[i];
                lane_in[i].signal_ok <= healthy[i];
                lane_in[i].rx_loss <= !healthy[i];
                lane_in[i].rx_ok <= healthy[i];
                lane_in[i].link_up <= healthy[i];
                lane_in[i].rx_linked <= healthy[i];
                lane_in[i].block_error <= err_req[i] && ph_q;
                lane_in[i].adapt_up <= up_req[i] && ph_q;
                lane_in[i].adapt_dn <= dn_req[i] && ph_q;
                lane_in[i].att <= 4'h4 + 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int W = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata;
    logic pready, pslverr;
    logic pll_ok = 1'b1, pll2_ok = 1'b0;
    logic [1:0] kr_mode = 2'b10, healthy = 2'b00, err_req = 2'b00;
    logic [1:0] dn_req = 2'b00, up_req = 2'b00;
    logic [1:0][7:0] env = '0;
    logic [1:0][W-1:0] tx_q = '0, ser_tx, ser_rx, rx_out;
    serdes_lane_status_pkg::lane_in_t [1:0] lane_in;
    serdes_lane_status_pkg::lane_out_t [1:0] lane_out;
    int err_count = 0, n_checks = 0;
    int n_cdr[2] = '{0, 0}, n_stg[2] = '{0, 0}, n_lrst[2] = '{0, 0};

    serdes_lane_status #(.SERDES_WIDTH(W)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_ok(pll_ok), .pll2_ok(pll2_ok), .kr_mode(kr_mode),
        .lane_in(lane_in), .lane_out(lane_out), .xgmii_tx_data(tx_q),
        .serdes_tx_data(ser_tx), .serdes_rx_data(ser_rx),
        .xgmii_rx_data(rx_out));
    link_partner #(.W(W)) partner (
        .pclk(pclk), .presetn(presetn), .healthy(healthy), .env(env),
        .err_req(err_req), .dn_req(dn_req), .up_req(up_req),
        .serdes_tx_data(ser_tx), .serdes_rx_data(ser_rx),
        .lane_in(lane_in));

    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        tx_q <= tx_q + 32'h0001_0003;
        for (int i = 0; i < 2; i++) begin
            if (lane_out[i].cdr_reset === 1'b1) n_cdr[i]++;
            if (lane_out[i].rx_stage_reset === 1'b1) n_stg[i]++;
            if (lane_out[i].lane_reset === 1'b1) n_lrst[i]++;
        end
    end

    // ----------------------------------------------------------------
    // Bus access and checking
    // ----------------------------------------------------------------
    task automatic print_verdict;
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 16) begin
            chk(32'h0000_0000, 32'h0000_0001);
            print_verdict();
        end
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] m,
            input logic [31:0] x, input logic ee);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, '0, r, e);
        chk(r & m, x);
        chk({31'h0000_0000, e}, {31'h0000_0000, ee});
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
        chk({31'h0000_0000, e}, 32'h0000_0000);
        repeat (4) @(posedge pclk);
    endtask
    task automatic toggle(input logic [31:0] a);
        wr(a, 32'hf000_1084);
        wr(a, 32'hf000_1080);
    endtask
    task automatic adapt(input logic up, input int n);
        dn_req[0] <= !up;
        up_req[0] <= up;
        repeat (n) @(posedge pclk);
        dn_req[0] <= 1'b0;
        up_req[0] <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        int c;
        logic [31:0] t;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(serdes_lane_status_pkg::ADDR_LANE0_CFG4, '1, 32'h0000_0080, 0);
        rd(serdes_lane_status_pkg::ADDR_PORT0_TX_CTL, '1, '0, 0);
        rd(serdes_lane_status_pkg::ADDR_PORT1_TX_CTL, '1, '0, 0);
        rd(32'h0000_0000, '1, '0, 1);
        for (int h = 1; h < 3; h++) begin
            healthy <= 2'(h);
            env <= (h == 1) ? 16'h00f8 : 16'hf800;
            repeat (4) @(posedge pclk);
            rd(serdes_lane_status_pkg::ADDR_PLL_LANE_STS,
                32'h1100_0303, 32'h1000_0000 | 32'(h) * 32'h0000_0101, 0);
            rd(serdes_lane_status_pkg::ADDR_LANE0_CTL_STS,
                32'h0010_0003, h == 1 ? 32'h0010_0002 : 32'h0000_0001, 0);
            rd(serdes_lane_status_pkg::ADDR_LANE1_CTL_STS,
                32'h0010_0003, h == 2 ? 32'h0010_0002 : 32'h0000_0001, 0);
        end
        healthy <= 2'b11;
        env <= 16'hf8f8;
        wr(serdes_lane_status_pkg::ADDR_LANE0_CFG4, 32'hf000_1080);
        for (int v = 8'hf0; v < 8'hf2; v++) begin
            env[0] <= 8'(v);
            repeat (4) @(posedge pclk);
            rd(serdes_lane_status_pkg::ADDR_PLL_LANE_STS,
                32'h0000_0001, 32'(v > 8'hf0), 0);
        end
        env[0] <= 8'h10;
        wr(serdes_lane_status_pkg::ADDR_LANE0_CFG4, 32'hf000_1006);
        chk(32'(n_stg[0]), 32'h0000_0000);
        wr(serdes_lane_status_pkg::ADDR_LANE0_CFG4, 32'hf000_1000);
        wr(serdes_lane_status_pkg::ADDR_LANE0_CFG4, 32'hf000_1086);
        chk(32'(lane_out[0].signal_detect), 32'h0000_0001);
        chk(32'(n_stg[0]), 32'h0000_0001);
        c = n_cdr[0];
        wr(serdes_lane_status_pkg::ADDR_LANE0_CFG4, 32'hf000_1084);
        chk(32'(lane_out[0].signal_detect), 32'h0000_0000);
        chk(32'(n_cdr[0] - c), 32'h0000_0001);
        env[0] <= 8'hf8;
        wr(serdes_lane_status_pkg::ADDR_LANE0_CFG4, 32'hf000_1080);
        chk(32'(lane_out[0].signal_detect), 32'h0000_0001);
        err_req[0] <= 1'b1;
        repeat (600) @(posedge pclk);
        err_req[0] <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(serdes_lane_status_pkg::ADDR_PORT0_RX_STS,
            32'h40ff_0000, 32'h40ff_0000, 0);
        toggle(serdes_lane_status_pkg::ADDR_LANE0_CFG4);
        chk(32'(n_lrst[0]), 32'h0000_0000);
        rd(serdes_lane_status_pkg::ADDR_PORT0_RX_STS,
            32'h00ff_0000, 32'h00ff_0000, 0);
        wr(serdes_lane_status_pkg::ADDR_PORT0_RX_STS, '0);
        rd(serdes_lane_status_pkg::ADDR_PORT0_RX_STS,
            32'h40ff_0000, 32'h4000_0000, 0);
        wr(serdes_lane_status_pkg::ADDR_LANE1_CFG4, 32'hf000_1084);
        chk(32'(n_lrst[1]), 32'h0000_0001);
        rd(serdes_lane_status_pkg::ADDR_PORT1_RX_STS,
            32'h4000_0000, 32'h4000_0000, 0);
        rd(serdes_lane_status_pkg::ADDR_PORT1_TX_CTL, '1, '0, 1);
        wr(serdes_lane_status_pkg::ADDR_LANE1_CFG4, 32'hf000_1080);
        rd(serdes_lane_status_pkg::ADDR_PORT1_RX_STS,
            32'h4000_0000, 32'h4000_0000, 0);
        wr(serdes_lane_status_pkg::ADDR_TBUS_SELECT,
            serdes_lane_status_pkg::TBUS_SEL_PORT0);
        rd(serdes_lane_status_pkg::ADDR_TBUS_READBACK,
            32'h0ff0_0000, 32'h0840_0000, 0);
        adapt(1'b0, 20);
        adapt(1'b1, 6);
        toggle(serdes_lane_status_pkg::ADDR_LANE0_CFG4);
        rd(serdes_lane_status_pkg::ADDR_TBUS_READBACK,
            32'h0ff0_0000, 32'h0040_0000, 0);
        wr(serdes_lane_status_pkg::ADDR_LANE0_CFG4, 32'hf000_1088);
        adapt(1'b1, 6);
        rd(serdes_lane_status_pkg::ADDR_TBUS_READBACK,
            32'h0ff0_0000, 32'h0b40_0000, 0);
        wr(serdes_lane_status_pkg::ADDR_TBUS_SELECT,
            serdes_lane_status_pkg::TBUS_SEL_PORT1);
        rd(serdes_lane_status_pkg::ADDR_TBUS_READBACK,
            32'h0ff0_0000, 32'h0850_0000, 0);
        wr(serdes_lane_status_pkg::ADDR_TBUS_SELECT, 32'h0410_0000);
        rd(serdes_lane_status_pkg::ADDR_TBUS_READBACK, '1, '0, 0);
        t = tx_q;
        repeat (3) @(posedge pclk);
        chk(rx_out, t);
        print_verdict();
    end
endmodule
`default_nettype wire
